// file: noncacheable_region_decoder.sv
/*
 * non-cacheable region decoder: three programmable regions, an
 * AXI4-Lite register slave, and a registered non-cacheable flag.
 * assumes cpu_addr is synchronous to aclk; flag follows one cycle later.
 */
// What this block does
// R1 - region 1 base lines 25..18 come from its high register bits 7..0
// R2 - region 2 base lines 17..14 come from its low register bits 7..4
// R3 - region 2 base lines 25..18 come from the register at index 0Fh
// R4 - region 3 base lines 17..14 come from its low register bits 7..4
// R5 - size code 0 means all cacheable; codes 13..15 disable caching
// R6 - codes 1..12 compare lines from 13+code up to 25, 16K to 32M
// R7 - region 1 base lines 17..14 and size sit in register 0Ch
// R8 - region 3 base lines 25..18 come from register 11h bits 7..0
// R9 - flag non-cacheable on any enabled region hit or any disable code
`timescale 1ns/1ps
`default_nettype none

module noncacheable_region_decoder (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address
	input  wire logic [7:0]  awaddr,
	input  wire logic [2:0]  awprot,
	input  wire logic        awvalid,
	output logic             awready,
	// axi4-lite write data
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// axi4-lite write response
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// axi4-lite read address
	input  wire logic [7:0]  araddr,
	input  wire logic [2:0]  arprot,
	input  wire logic        arvalid,
	output logic             arready,
	// axi4-lite read data
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// cpu address and cache controller
	input  wire logic [25:0] cpu_addr,
	output logic             non_cacheable
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [7:0] cfg          [noncacheable_region_pkg::NUM_REGS];
	logic [7:0] next_cfg     [noncacheable_region_pkg::NUM_REGS];
	logic       aw_held;
	logic       next_aw_held;
	logic       w_held;
	logic       next_w_held;
	logic [5:0] waddr_q;
	logic [5:0] next_waddr_q;
	logic [7:0] wbyte_q;
	logic [7:0] next_wbyte_q;
	logic       wlane_q;
	logic       next_wlane_q;
	logic       next_bvalid;
	logic [1:0] next_bresp;
	logic       next_rvalid;
	logic [1:0] next_rresp;
	logic [31:0] next_rdata;
	logic       next_non_cacheable;
	logic [2:0] region_hit;
	logic [2:0] region_disable;

	// slot of an index inside the register array, valid when mapped
	function automatic logic mapped(input logic [5:0] idx);
		mapped = (idx >= noncacheable_region_pkg::IDX_R1_BASE_LOW_SIZE) &&
			(idx <= noncacheable_region_pkg::IDX_R3_BASE_HIGH);
	endfunction

	function automatic logic [2:0] slot(input logic [5:0] idx);
		logic [5:0] diff;
		diff = idx - noncacheable_region_pkg::IDX_R1_BASE_LOW_SIZE;
		slot = diff[2:0];
	endfunction

	// ---------------------------------------------------------------
	// bus handshakes
	// ---------------------------------------------------------------
	// one write at a time: address and data wait here until both came
	assign awready = !aw_held && !bvalid;
	assign wready  = !w_held && !bvalid;
	assign arready = !rvalid;

	// ---------------------------------------------------------------
	// register file and bus slave
	// ---------------------------------------------------------------
	// next values for bus channel state and the configuration bytes
	always_comb begin
		for (int i = 0; i < noncacheable_region_pkg::NUM_REGS; i++) begin
			next_cfg[i] = cfg[i];
		end
		next_aw_held = aw_held;
		next_w_held  = w_held;
		next_waddr_q = waddr_q;
		next_wbyte_q = wbyte_q;
		next_wlane_q = wlane_q;
		next_bvalid  = bvalid;
		next_bresp   = bresp;
		next_rvalid  = rvalid;
		next_rresp   = rresp;
		next_rdata   = rdata;
		if (awvalid && awready) begin
			next_aw_held = 1'b1;
			next_waddr_q = awaddr[7:2];
		end
		if (wvalid && wready) begin
			next_w_held  = 1'b1;
			next_wbyte_q = wdata[7:0];
			next_wlane_q = wstrb[0];
		end
		// both halves present: commit and answer next cycle
		if (aw_held && w_held) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			if (mapped(waddr_q)) begin
				next_bresp = noncacheable_region_pkg::RESP_OKAY;
				if (wlane_q) begin // only lane 0 carries register bits
					next_cfg[slot(waddr_q)] = wbyte_q; // [R1] [R2] [R3] [R4] [R7] [R8]
				end
			end else begin
				next_bresp = noncacheable_region_pkg::RESP_SLVERR;
			end
		end
		if (bvalid && bready) begin
			next_bvalid = 1'b0;
		end
		// reads answer one cycle after the address is taken
		if (arvalid && arready) begin
			next_rvalid = 1'b1;
			if (mapped(araddr[7:2])) begin
				next_rdata = {24'h000000, cfg[slot(araddr[7:2])]};
				next_rresp = noncacheable_region_pkg::RESP_OKAY;
			end else begin
				next_rdata = 32'h00000000;
				next_rresp = noncacheable_region_pkg::RESP_SLVERR;
			end
		end else if (rvalid && rready) begin
			next_rvalid = 1'b0;
		end
	end

	// register the bus slave and configuration state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < noncacheable_region_pkg::NUM_REGS; i++) begin
				cfg[i] <= noncacheable_region_pkg::REG_RESET; // all cacheable [R5]
			end
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			waddr_q <= 6'h00;
			wbyte_q <= 8'h00;
			wlane_q <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= noncacheable_region_pkg::RESP_OKAY;
			rvalid  <= 1'b0;
			rresp   <= noncacheable_region_pkg::RESP_OKAY;
			rdata   <= 32'h00000000;
		end else begin
			for (int i = 0; i < noncacheable_region_pkg::NUM_REGS; i++) begin
				cfg[i] <= next_cfg[i];
			end
			aw_held <= next_aw_held;
			w_held  <= next_w_held;
			waddr_q <= next_waddr_q;
			wbyte_q <= next_wbyte_q;
			wlane_q <= next_wlane_q;
			bvalid  <= next_bvalid;
			bresp   <= next_bresp;
			rvalid  <= next_rvalid;
			rresp   <= next_rresp;
			rdata   <= next_rdata;
		end
	end

	// ---------------------------------------------------------------
	// region compare
	// ---------------------------------------------------------------
	// each region is a low byte (base 17..14, size) then a high byte
	for (genvar r = 0; r < noncacheable_region_pkg::NUM_REGIONS;
		r++) begin : g_region
		logic [11:0] base;
		logic [11:0] cmp_mask;
		logic [3:0]  size;
		logic        enabled;
		assign size = cfg[2*r][noncacheable_region_pkg::SIZE_MSB:
			noncacheable_region_pkg::SIZE_LSB];
		assign base = {cfg[2*r+1], // lines 25..18 [R1] [R3] [R8]
			cfg[2*r][noncacheable_region_pkg::LOW_BASE_MSB:
			noncacheable_region_pkg::LOW_BASE_LSB]}; // [R2] [R4] [R7]
		// line 14+j is compared once code <= j+1; code 12 keeps line 25
		for (genvar j = 0; j < noncacheable_region_pkg::CMP_W;
			j++) begin : g_bit
			assign cmp_mask[j] = ({1'b0, size} <= 5'(j + 1)); // [R6]
		end
		assign enabled = (size != noncacheable_region_pkg::SIZE_ALL_CACHEABLE)
			&& (size <= noncacheable_region_pkg::SIZE_LARGEST); // [R5]
		assign region_hit[r] = enabled &&
			(((cpu_addr[25:14] ^ base) & cmp_mask) == 12'h000); // [R6]
		assign region_disable[r] =
			(size > noncacheable_region_pkg::SIZE_LARGEST); // [R5]
	end

	// ---------------------------------------------------------------
	// non-cacheable flag
	// ---------------------------------------------------------------
	// registered so the cache controller sees a glitch-free level
	always_comb begin
		next_non_cacheable = (|region_hit) || (|region_disable); // [R9]
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			non_cacheable <= 1'b0;
		end else begin
			non_cacheable <= next_non_cacheable;
		end
	end

endmodule // noncacheable_region_decoder

`default_nettype wire

// file: noncacheable_region_pkg.sv
/*
 * constants for the non-cacheable region decoder: register indices,
 * field positions, size codes, reset values and bus answers.
 * assumes a 32-bit AXI4-Lite register bus and a 26-bit cpu address.
 */
`default_nettype none

package noncacheable_region_pkg;

	// ---------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ---------------------------------------------------------------
	localparam logic [5:0] IDX_R1_BASE_LOW_SIZE = 6'h0C;
	localparam logic [5:0] IDX_R1_BASE_HIGH     = 6'h0D;
	localparam logic [5:0] IDX_R2_BASE_LOW_SIZE = 6'h0E;
	localparam logic [5:0] IDX_R2_BASE_HIGH     = 6'h0F;
	localparam logic [5:0] IDX_R3_BASE_LOW_SIZE = 6'h10;
	localparam logic [5:0] IDX_R3_BASE_HIGH     = 6'h11;
	localparam int         NUM_REGS             = 6;
	localparam int         NUM_REGIONS          = 3;

	// ---------------------------------------------------------------
	// field layout
	// ---------------------------------------------------------------
	localparam int         CPU_ADDR_W     = 26;
	localparam int         CMP_LSB        = 14;  // lowest compared line
	localparam int         CMP_W          = 12;  // lines 25..14
	localparam int         LOW_BASE_MSB   = 7;   // low reg bits 7..4
	localparam int         LOW_BASE_LSB   = 4;
	localparam int         SIZE_MSB       = 3;   // low reg bits 3..0
	localparam int         SIZE_LSB       = 0;
	localparam int         BUS_ADDR_W     = 8;
	localparam logic [7:0] REG_RESET      = 8'h00;

	// ---------------------------------------------------------------
	// size codes
	// ---------------------------------------------------------------
	localparam logic [3:0] SIZE_ALL_CACHEABLE = 4'h0;
	localparam logic [3:0] SIZE_LARGEST       = 4'hC; // 32M, line 25 only

	// ---------------------------------------------------------------
	// bus answers
	// ---------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

// file: cpu_bus_model.sv
/* cpu address bus model: puts the address the bench asks for on the bus.
   assumes the bench changes req just after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
	// clock
	input  wire logic        aclk,
	// bench request and cpu bus
	input  wire logic [25:0] req,
	output var logic  [25:0] cpu_addr
);
	// launch on the edge like a cpu bus; defined from time zero
	// one process only, so the bus has a single driver
	initial begin
		cpu_addr = 26'h0;
		forever @(posedge aclk) cpu_addr <= req;
	end
endmodule // cpu_bus_model
`default_nettype wire

// file: ncr_assertions.sv
/* checker for the region decoder: bus handshakes and reset flag.
   assumes the bind below attaches it to the decoder ports. */
`timescale 1ns/1ps
`default_nettype none
module ncr_chk (
	// clock and reset
	input wire logic        aclk, aresetn,
	// handshakes and answers
	input wire logic        awvalid, awready, wvalid, wready, bvalid,
	input wire logic        bready, arvalid, arready, rvalid, rready,
	input wire logic [1:0]  bresp,
	input wire logic [31:0] rdata,
	// decoder flag
	input wire logic        non_cacheable
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// a write parks in the hold stage for one edge, then answers; a read
	// answers one edge after the address is taken
	property p_wl; awvalid && awready && wvalid && wready |=> ##1 bvalid;
	endproperty
	a_wl: assert property (p_wl) else $error("no write answer");
	property p_rl; arvalid && arready |=> rvalid; endproperty
	a_rl: assert property (p_rl) else $error("no read answer");
	// one write and one read in flight, so no new request while answering
	property p_bb; bvalid |-> !awready && !wready; endproperty
	a_bb: assert property (p_bb) else $error("write taken during answer");
	property p_rb; rvalid |-> !arready; endproperty
	a_rb: assert property (p_rb) else $error("read taken during answer");
	property p_bd; bvalid && bready |=> !bvalid; endproperty
	a_bd: assert property (p_bd) else $error("write answer repeated");
	property p_rd; rvalid && rready |=> !rvalid; endproperty
	a_rd: assert property (p_rd) else $error("read answer repeated");
	property p_bc; bvalid |-> bresp inside {2'h0, 2'h2}; endproperty
	a_bc: assert property (p_bc) else $error("bad write response");
	// byte registers: the upper bits of a word always read zero
	property p_up; rvalid |-> rdata[31:8] == 24'h0; endproperty
	a_up: assert property (p_up) else $error("upper read bits set");
	property p_rs; $rose(aresetn) |-> !non_cacheable; endproperty
	a_rs: assert property (p_rs) else $error("flag set out of reset");
	c_wr: cover property (bvalid && bready);
	c_rd: cover property (rvalid && rready);
	c_nc: cover property (non_cacheable);
endmodule // ncr_chk
bind noncacheable_region_decoder ncr_chk u_chk (.aclk, .aresetn,
	.awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .arvalid,
	.arready, .rvalid, .rready, .bresp, .rdata, .non_cacheable);
`default_nettype wire

// file: noncacheable_region_decoder_tb_top.sv
/* bench for the region decoder: bus tasks, readback and decode sweeps.
   assumes the package, decoder, cpu model and checker are compiled. */
`timescale 1ns/1ps
`default_nettype none
module noncacheable_region_decoder_tb_top;
	localparam logic [1:0] OK = noncacheable_region_pkg::RESP_OKAY;
	localparam logic [1:0] ER = noncacheable_region_pkg::RESP_SLVERR;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, non_cacheable;
	logic [7:0]  awaddr, araddr;
	logic [2:0]  awprot, arprot;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [25:0] req, cpu_addr, b, m;
	logic [5:0]  lo;
	int          num_errors = 0, comparisons = 0, cycles = 0;
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	// a hang ends the run; a clean run needs under two thousand cycles
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			num_errors++;
			report_and_stop();
		end
	end
	noncacheable_region_decoder dut (.aclk, .aresetn, .awaddr, .awprot,
		.awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
		.bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .cpu_addr, .non_cacheable);
	cpu_bus_model cpu (.aclk, .req, .cpu_addr);
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// bready and rready stay high, so answers are taken at once
	task automatic wr(input logic [5:0] i, input logic [7:0] d,
		input logic [3:0] s, input logic [1:0] er);
		{awaddr, wdata, wstrb} <= {i, 2'h0, 24'h0, d, s};
		{awvalid, wvalid} <= 2'h3;
		forever begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				chk({30'h0, bresp}, {30'h0, er});
				break;
			end
		end
	endtask
	task automatic rd(input logic [5:0] i, input logic [7:0] d,
		input logic [1:0] er);
		araddr <= {i, 2'h0};
		arvalid <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				chk(rdata, {24'h0, d});
				chk({30'h0, rresp}, {30'h0, er});
				break;
			end
		end
	endtask
	// one edge in the cpu model, one in the decoder; the third edge
	// samples the settled flag, so the next request starts on an edge
	task automatic pr(input logic [25:0] a, input logic e);
		req <= a;
		repeat (3) @(posedge aclk);
		chk({31'h0, non_cacheable}, {31'h0, e});
	endtask
	task automatic report_and_stop();
		if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		{aresetn, awvalid, wvalid, arvalid, awprot, arprot} = '0;
		{awaddr, araddr, wdata, wstrb, req} = '0;
		{bready, rready} = 2'h3;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		// reset values, then the unmapped word
		for (int i = 0; i < 7; i++) rd(6'h0C + 6'(i), 8'h0, i < 6 ? OK : ER);
		wr(6'h12, 8'hFF, 4'h1, ER);
		wr(6'h0C, 8'h33, 4'h0, OK);
		rd(6'h0C, 8'h00, OK);
		// each region alone through every size code
		for (int r = 0; r < 3; r++) begin
			lo = 6'h0C + 6'(2 * r);
			b = {8'h96 + 8'(r), 4'h9, 14'h0};
			wr(lo + 6'h1, b[25:18], 4'h1, OK);
			rd(lo + 6'h1, b[25:18], OK);
			for (int c = 0; c < 16; c++) begin
				wr(lo, {4'h9, 4'(c)}, 4'h1, OK);
				m = 26'h1 << (13 + c);
				if (c == 0) pr(b, 1'b0);
				else if (c > 12) pr(26'h0, 1'b1);
				else begin
					pr(b | (m - 26'h1), 1'b1);
					pr(b ^ m, 1'b0);
				end
			end
			rd(lo, 8'h9F, OK);
			wr(lo, 8'h00, 4'h1, OK);
			wr(lo + 6'h1, 8'h00, 4'h1, OK);
		end
		// a reset in mid-run must clear a live disable code
		wr(6'h0C, 8'h0D, 4'h1, OK);
		pr(26'h0, 1'b1);
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		pr(26'h0, 1'b0);
		rd(6'h0C, 8'h00, OK);
		report_and_stop();
	end
endmodule // noncacheable_region_decoder_tb_top
`default_nettype wire
